// *** logic/port_pkg.sv ***
// Constants, register map and carrier types for the port latch and pull-up block
package port_pkg;

    // Port slots, in order: ports 0, 1, 3, 4, 5, 6, 7, 12, 14
    localparam int NUM_PORTS = 9;
    localparam int ADDR_W = 20;
    localparam int IDX_W = 16;

    // Register indices; byte address is four times the index
    localparam logic [NUM_PORTS-1:0][IDX_W-1:0] LATCH_IDX = {
        16'hFF0E, 16'hFF0C, 16'hFF07, 16'hFF06, 16'hFF05,
        16'hFF04, 16'hFF03, 16'hFF01, 16'hFF00};
    localparam logic [NUM_PORTS-1:0][IDX_W-1:0] PULLUP_IDX = {
        16'hFF3E, 16'hFF3C, 16'hFF37, 16'hFF36, 16'hFF35,
        16'hFF34, 16'hFF33, 16'hFF31, 16'hFF30};
    localparam logic [NUM_PORTS-1:0][IDX_W-1:0] MODE_IDX = {
        16'hFF2E, 16'hFF2C, 16'hFF27, 16'hFF26, 16'hFF25,
        16'hFF24, 16'hFF23, 16'hFF21, 16'hFF20};
    localparam logic [NUM_PORTS-1:0][IDX_W-1:0] BITOP_IDX = {
        16'hFF6E, 16'hFF6C, 16'hFF67, 16'hFF66, 16'hFF65,
        16'hFF64, 16'hFF63, 16'hFF61, 16'hFF60};

    // Implemented bits per slot
    localparam logic [NUM_PORTS-1:0][7:0] PULLUP_MASK = {
        8'h3F, 8'h01, 8'hFF, 8'hF0, 8'hFF, 8'hFF, 8'h0F, 8'hFF, 8'h7F};
    localparam logic [NUM_PORTS-1:0][7:0] PIN_MASK = {
        8'h3F, 8'h01, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h0F, 8'hFF, 8'h7F};

    // Values after reset
    localparam logic [7:0] LATCH_RST = 8'h00;
    localparam logic [7:0] MODE_RST = 8'hFF;
    localparam logic [7:0] PULLUP_RST = 8'h00;
    localparam logic [7:0] SYNC_RST = 8'h00;

    // Bit operation command fields
    localparam int BITOP_SEL_LSB = 0;
    localparam int BITOP_OP_LSB = 4;

    typedef enum logic [1:0] {
        BOP_CLEAR = 2'h0,
        BOP_SET = 2'h1,
        BOP_TOGGLE = 2'h2,
        BOP_KEEP = 2'h3
    } bitop_t;

    typedef struct packed {
        logic [7:0] out;
        logic [7:0] oe;
        logic [7:0] pu_en;
    } port_pads_t;

    typedef struct packed {
        logic [7:0] oe;
        logic [7:0] out;
    } alt_drive_t;

endpackage

// *** logic/pin_sync.sv ***
// Two-flop synchroniser for one 8-bit group of pin levels
`timescale 1ns/100ps
module pin_sync
    import port_pkg::*;
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Levels
    input wire logic [7:0] async_in,
    output logic [7:0] sync_out
);

    logic [7:0] meta_q;
    logic [7:0] sync_q;

    // First stage feeds only the second stage
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_q <= SYNC_RST;
            sync_q <= SYNC_RST;
        end else begin
            meta_q <= async_in;
            sync_q <= meta_q;
        end
    end

    assign sync_out = sync_q;

endmodule

// *** logic/bit_op.sv ***
// Single-bit manipulation applied to a whole 8-bit port operand
`timescale 1ns/100ps
module bit_op
    import port_pkg::*;
(
    // Operand and command
    input wire logic [7:0] operand,
    input wire logic [2:0] bit_sel,
    input wire bitop_t op,
    // Result for the whole port
    output logic [7:0] result
);

    logic [7:0] onehot;

    assign onehot = 8'h01 << bit_sel;

    // The other seven bits are written back as read, so input-mode
    // neighbours pick up their pin level into the latch
    always_comb begin
        case (op)
            BOP_CLEAR: result = operand & ~onehot;
            BOP_SET: result = operand | onehot;
            BOP_TOGGLE: result = operand ^ onehot;
            default: result = operand;
        endcase
    end

endmodule

// *** logic/port_latch_pullup.sv ***
// General-purpose port block: output latches, modes, pull-ups, APB slave
`timescale 1ns/100ps
module port_latch_pullup
    import port_pkg::*;
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Pins
    input wire logic [NUM_PORTS-1:0][7:0] pin_in,
    output port_pads_t [NUM_PORTS-1:0] pads,
    // Alternate-function drive from on-chip peripherals
    input wire alt_drive_t [NUM_PORTS-1:0] alt
);

    logic [IDX_W-1:0] idx;
    logic addr_ok;
    logic setup;
    logic wr_en;
    logic [NUM_PORTS-1:0] hit_lat;
    logic [NUM_PORTS-1:0] hit_mode;
    logic [NUM_PORTS-1:0] hit_pu;
    logic [NUM_PORTS-1:0] hit_bop;
    logic [NUM_PORTS-1:0][7:0] latch_q;
    logic [NUM_PORTS-1:0][7:0] mode_q;
    logic [NUM_PORTS-1:0][7:0] pu_q;
    logic [NUM_PORTS-1:0][7:0] pin_s;
    logic [NUM_PORTS-1:0][7:0] port_view;
    logic [NUM_PORTS-1:0][7:0] bop_res;
    logic [31:0] rdata_d;
    logic [31:0] rdata_q;
    logic err_d;
    logic err_q;

    // Index decode; misaligned or out-of-range addresses match nothing
    assign idx = paddr[IDX_W+1:2];
    assign addr_ok = (paddr[1:0] == 2'h0) && (paddr[ADDR_W-1:IDX_W+2] == '0);
    assign setup = psel && !penable;
    // Zero wait states: every access phase completes at once
    assign pready = psel && penable;
    assign wr_en = psel && penable && pwrite && !err_q && pstrb[0];

    genvar g;
    generate
        for (g = 0; g < NUM_PORTS; g++) begin : gen_port
            assign hit_lat[g] = addr_ok && (idx == LATCH_IDX[g]);
            assign hit_mode[g] = addr_ok && (idx == MODE_IDX[g]);
            assign hit_pu[g] = addr_ok && (idx == PULLUP_IDX[g]);
            assign hit_bop[g] = addr_ok && (idx == BITOP_IDX[g]);

            pin_sync u_sync (
                .pclk(pclk),
                .presetn(presetn),
                .async_in(pin_in[g]),
                .sync_out(pin_s[g])
            );

            // Mode bit 1 means input: read the pin there, the latch elsewhere
            assign port_view[g] = ((mode_q[g] & pin_s[g])
                                  | (~mode_q[g] & latch_q[g]))
                                  & PIN_MASK[g];

            bit_op u_bop (
                .operand(port_view[g]),
                .bit_sel(pwdata[BITOP_SEL_LSB +: 3]),
                .op(bitop_t'(pwdata[BITOP_OP_LSB +: 2])),
                .result(bop_res[g])
            );

            // Latch is written in either mode and held otherwise
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    latch_q[g] <= LATCH_RST;
                end else if (wr_en && hit_lat[g]) begin
                    latch_q[g] <= pwdata[7:0] & PIN_MASK[g];
                end else if (wr_en && hit_bop[g]) begin
                    // Whole byte written back, not just the chosen bit
                    latch_q[g] <= bop_res[g] & PIN_MASK[g];
                end
            end

            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    mode_q[g] <= MODE_RST;
                end else if (wr_en && hit_mode[g]) begin
                    mode_q[g] <= pwdata[7:0] | ~PIN_MASK[g];
                end
            end

            // Byte-wide writes serve both single-bit and full-byte software updates
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    pu_q[g] <= PULLUP_RST;
                end else if (wr_en && hit_pu[g]) begin
                    pu_q[g] <= pwdata[7:0] & PULLUP_MASK[g];
                end
            end

            // Pad drive: alternate output wins over the latch when enabled
            assign pads[g].out = (alt[g].oe & alt[g].out)
                                 | (~alt[g].oe & latch_q[g]);
            assign pads[g].oe = (alt[g].oe | ~mode_q[g]) & PIN_MASK[g];
            // Pull-up is cut whenever anything drives the pin
            assign pads[g].pu_en = pu_q[g] & mode_q[g] & ~alt[g].oe;
        end
    endgenerate

    // Read data is gathered in the setup cycle so prdata comes from a flop
    always_comb begin
        rdata_d = 32'h0000_0000;
        err_d = 1'b1;
        for (int i = 0; i < NUM_PORTS; i++) begin
            if (hit_lat[i] || hit_bop[i]) begin
                rdata_d[7:0] = port_view[i];
                err_d = 1'b0;
            end
            if (hit_mode[i]) begin
                rdata_d[7:0] = mode_q[i];
                err_d = 1'b0;
            end
            if (hit_pu[i]) begin
                rdata_d[7:0] = pu_q[i];
                err_d = 1'b0;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rdata_q <= 32'h0000_0000;
            err_q <= 1'b0;
        end else if (setup) begin
            rdata_q <= pwrite ? 32'h0000_0000 : rdata_d;
            err_q <= err_d;
        end
    end

    assign prdata = rdata_q;
    assign pslverr = pready && err_q;

endmodule

// *** test/port_properties.sv ***
// Checker for the port block's bus handshake and pad outputs
`timescale 1ns/100ps
module port_properties
    import port_pkg::*;
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Bus
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic pready,
    // Pads
    input wire port_pads_t [NUM_PORTS-1:0] pads,
    input wire alt_drive_t [NUM_PORTS-1:0] alt
);
    default clocking @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    a_zero_wait: assert property (psel && penable |-> pready)
        else $error("no ready in access");
    a_pu_excl: assert property ((pads[1].pu_en & pads[1].oe) == 8'h00)
        else $error("pull-up on driven pin");
    a_p6_nopu: assert property (pads[5].pu_en[3:0] == 4'h0)
        else $error("pull-up on port 6 low pin");
    a_unimpl_pu: assert property (pads[7].pu_en[7:1] == 7'h00)
        else $error("pull-up on missing pin");
    a_alt_wins: assert property (alt[1].oe == 8'hFF |->
        pads[1].oe == 8'hFF && pads[1].pu_en == 8'h00 && pads[1].out == alt[1].out)
        else $error("alternate drive lost");
    a_latch_hold: assert property (alt[1].oe == 8'h00 && $past(alt[1].oe) == 8'h00
        && !($past(pready) && $past(pwrite)) |-> $stable(pads[1].out))
        else $error("pin value moved without a write");
    a_rst_latch: assert property ($rose(presetn) |-> pads[1].out == 8'h00)
        else $error("latch not clear after reset");
    a_rst_oe: assert property ($rose(presetn) |-> pads[1].oe == alt[1].oe)
        else $error("buffer on after reset");
    c_write: cover property (pready && pwrite);
    c_read: cover property (pready && !pwrite);
    c_alt: cover property (alt[1].oe == 8'hFF);
endmodule

bind port_latch_pullup port_properties port_properties_inst (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pready(pready), .pads(pads), .alt(alt));

// *** test/pin_partner.sv ***
// External circuitry on the port pins: other drivers, pull-ups, floating lines
`timescale 1ns/100ps
module pin_partner
    import port_pkg::*;
(
    // Clock
    input wire logic pclk,
    // Pads and outside drivers
    input wire port_pads_t [NUM_PORTS-1:0] pads,
    input wire logic [NUM_PORTS-1:0][7:0] ext_out,
    input wire logic [NUM_PORTS-1:0][7:0] ext_oe,
    output logic [NUM_PORTS-1:0][7:0] pin_in
);
    logic [7:0] float_q = 8'h55;
    // Undriven pins wander so no check can lean on a stale level
    always_ff @(posedge pclk) begin
        float_q <= ~float_q;
    end
    always_comb begin
        for (int i = 0; i < NUM_PORTS; i++) begin
            pin_in[i] = pads[i].oe & pads[i].out | ~pads[i].oe & (ext_oe[i] & ext_out[i]
                | ~ext_oe[i] & (pads[i].pu_en | float_q));
        end
    end
endmodule

// *** test/tb.sv ***
// Self-checking bench for the port latch and pull-up block
`timescale 1ns/100ps
module tb
    import port_pkg::*;
;
    logic pclk = 1'b0;
    logic presetn, psel, penable, pwrite, pready, pslverr, err;
    logic [ADDR_W-1:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0] pstrb;
    logic [NUM_PORTS-1:0][7:0] pin_in, ext_out, ext_oe;
    port_pads_t [NUM_PORTS-1:0] pads;
    alt_drive_t [NUM_PORTS-1:0] alt;
    logic [7:0] v, p, m, x;
    int seed, fails, comparisons, lat, mode, b;
    port_latch_pullup port_latch_pullup_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .pin_in(pin_in), .pads(pads),
        .alt(alt));
    pin_partner pin_partner_inst (.pclk(pclk), .pads(pads), .ext_out(ext_out),
        .ext_oe(ext_oe), .pin_in(pin_in));
    initial begin
        forever #5 pclk = ~pclk;
    end
    // Model of the slot 1 read view: pins for input bits, latch for output bits
    function automatic logic [31:0] view();
        return 32'(((mode & p) | (~mode & lat)) & 255);
    endfunction
    task automatic apb(input logic wr, input logic [IDX_W-1:0] idx, input logic [7:0] wd,
        input logic [3:0] st);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= {2'h0, idx, 2'h0};
        pwdata <= {24'h0, wd};
        pstrb <= st;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("Error t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic test_done();
        $display("fails=%0d comparisons=%0d", fails, comparisons);
        if (fails == 0 && comparisons > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (2000) @(posedge pclk);
        fails++;
        test_done();
    end
    initial begin
        seed = 43000;
        {presetn, psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
        alt = '0;
        ext_out = '0;
        ext_oe = '0;
        lat = 0;
        mode = 255;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        chk({24'h0, pads[1].out}, {24'h0, LATCH_RST});
        for (int i = 0; i < NUM_PORTS; i++) begin
            apb(1'b0, PULLUP_IDX[i], 8'h00, 4'hF);
            chk(rd, 32'h0);
            v = 8'($random(seed));
            apb(1'b1, PULLUP_IDX[i], v, 4'hF);
            apb(1'b0, PULLUP_IDX[i], 8'h00, 4'hF);
            chk(rd, {24'h0, v & PULLUP_MASK[i]});
            chk({24'h0, pads[i].pu_en}, {24'h0, v & PULLUP_MASK[i]});
        end
        p = 8'($random(seed));
        ext_out[1] <= p;
        ext_oe[1] <= 8'hFF;
        v = 8'($random(seed));
        apb(1'b1, LATCH_IDX[1], v, 4'hF);
        lat = v;
        chk({24'h0, pads[1].oe}, 32'h0);
        apb(1'b0, LATCH_IDX[1], 8'h00, 4'hF);
        chk(rd, view());
        m = 8'($random(seed));
        apb(1'b1, MODE_IDX[1], m, 4'hF);
        mode = m;
        chk({24'h0, pads[1].oe}, {24'h0, ~m});
        chk({24'h0, pads[1].out}, 32'(lat));
        apb(1'b0, LATCH_IDX[1], 8'h00, 4'hF);
        chk(rd, view());
        apb(1'b1, LATCH_IDX[1], ~v, 4'h0);
        chk({24'h0, pads[1].out}, 32'(lat));
        for (int op = 0; op < 4; op++) begin
            b = $random(seed) & 7;
            apb(1'b1, BITOP_IDX[1], 8'(op * 16 + b), 4'hF);
            x = 8'(view());
            case (op)
                0: x[b] = 1'b0;
                1: x[b] = 1'b1;
                2: x[b] = ~x[b];
                default: x[b] = x[b];
            endcase
            lat = x;
            chk({24'h0, pads[1].out}, 32'(lat));
            apb(1'b0, BITOP_IDX[1], 8'h00, 4'hF);
            chk(rd, view());
        end
        apb(1'b1, 16'hFF02, 8'hFF, 4'hF);
        chk({31'h0, err}, 32'h1);
        alt[1] <= '{oe: 8'hFF, out: v};
        repeat (2) @(posedge pclk);
        chk({16'h0, pads[1].out, pads[1].pu_en}, {16'h0, v, 8'h00});
        alt[1] <= '0;
        @(posedge pclk);
        test_done();
    end
endmodule
